//--- hdl/reset_cause_pkg.sv
package reset_cause_pkg;

    // ****************************************
    // Bus geometry.
    // ****************************************
    localparam int          AVS_ADDR_W   = 4;
    localparam int          AVS_DATA_W   = 32;
    localparam int          AVS_BE_W     = 4;
    localparam int          REG_W        = 16;
    localparam logic [3:0]  CAUSE_OFFSET = 4'h0;

    // ****************************************
    // Field positions of the cause and control register.
    // ****************************************
    localparam int BIT_TRAP_CONFLICT  = 15;
    localparam int BIT_ILLEGAL_OP     = 14;
    localparam int BIT_SW_BROWNOUT_EN = 13;
    localparam int BIT_RETENTION_EN   = 12;
    localparam int BIT_CONFIG_MISM    = 9;
    localparam int BIT_FAST_WAKE      = 8;
    localparam int BIT_PIN_RESET      = 7;
    localparam int BIT_SOFT_RESET     = 6;
    localparam int BIT_SW_WATCHDOG_EN = 5;
    localparam int BIT_WATCHDOG_TO    = 4;
    localparam int BIT_SLEEP          = 3;
    localparam int BIT_IDLE           = 2;
    localparam int BIT_BROWNOUT       = 1;
    localparam int BIT_POWER_ON       = 0;

    // ****************************************
    // Reset values and masks.
    // ****************************************
    localparam logic [15:0] POWER_ON_VALUE = 16'h2003;
    localparam logic [15:0] STATUS_MASK    = 16'hc2df;
    localparam logic [15:0] CTRL_MASK      = 16'h3120;
    localparam logic [15:0] CTRL_DEFAULT   = 16'h2000;
    localparam logic [1:0]  WATCHDOG_CFG_ALWAYS = 2'h3;
    localparam logic [1:0]  BROWNOUT_CFG_SW     = 2'h1;

    // ****************************************
    // Types.
    // ****************************************
    typedef struct packed {
        logic trap_conflict;
        logic illegal_opcode;
        logic illegal_addr_mode;
        logic uninit_pointer_reset;
        logic config_mismatch;
        logic reset_instr;
        logic watchdog_timeout;
        logic brownout;
    } reset_src_t;

    typedef struct packed {
        logic watchdog_clear_instr;
        logic power_save_instr;
        logic power_save_idle;
    } instr_evt_t;

    typedef struct packed {
        logic watchdog_enable;
        logic sw_brownout_enable;
        logic retention_enable;
        logic fast_wake_select;
    } power_ctl_t;

    typedef enum logic [1:0] {
        SLV_WAIT   = 2'b01,
        SLV_ANSWER = 2'b10
    } slv_state_t;

    // Expands the two low byte enables into a bit mask.
    function automatic logic [15:0] lane_mask(input logic [3:0] be);
        lane_mask = {{8{be[1]}}, {8{be[0]}}};
    endfunction

endpackage

//--- hdl/sync_two_flop.sv
`timescale 1ns/1ps
module sync_two_flop #(
    parameter int          WIDTH = 1,
    parameter logic [31:0] INIT  = 32'h0
) (
    input  wire logic             ref_clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    // ****************************************
    // Two flip-flops; only the second reads the first.
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta_r   <= INIT[WIDTH-1:0];
            sync_out <= INIT[WIDTH-1:0];
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

//--- hdl/avmm_reg_slave.sv
`timescale 1ns/1ps
module avmm_reg_slave (
    input  wire logic                                ref_clk,
    input  wire logic                                resetn,
    input  wire logic [reset_cause_pkg::AVS_ADDR_W-1:0] avs_address,
    input  wire logic                                avs_read,
    input  wire logic                                avs_write,
    input  wire logic [reset_cause_pkg::AVS_DATA_W-1:0] avs_writedata,
    input  wire logic [reset_cause_pkg::AVS_BE_W-1:0]   avs_byteenable,
    output logic      [reset_cause_pkg::AVS_DATA_W-1:0] avs_readdata,
    output logic                                     avs_waitrequest,
    input  wire logic [reset_cause_pkg::REG_W-1:0]      reg_value,
    output logic                                     reg_wr_en,
    output logic      [reset_cause_pkg::REG_W-1:0]      reg_wr_data,
    output logic      [reset_cause_pkg::REG_W-1:0]      reg_wr_mask
);
    import reset_cause_pkg::*;

    slv_state_t state_r;
    logic       hit;
    logic       req;

    assign hit = (avs_address == CAUSE_OFFSET);
    assign req = avs_read | avs_write;

    // ****************************************
    // One wait cycle, then the answer cycle.
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r         <= SLV_WAIT;
            avs_waitrequest <= 1'b1;
        end else begin
            case (state_r)
                SLV_WAIT: begin
                    if (req) begin
                        state_r         <= SLV_ANSWER;
                        avs_waitrequest <= 1'b0;
                    end
                end
                SLV_ANSWER: begin
                    state_r         <= SLV_WAIT;
                    avs_waitrequest <= 1'b1;
                end
                default: begin
                    state_r         <= SLV_WAIT;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // ****************************************
    // Read data; unmapped addresses read zero.
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            avs_readdata <= 32'h0;
        end else if (state_r == SLV_WAIT && avs_read) begin
            avs_readdata <= hit ? {16'h0, reg_value} : 32'h0;
        end
    end

    assign reg_wr_en   = avs_write && hit && (state_r == SLV_ANSWER);
    assign reg_wr_data = avs_writedata[REG_W-1:0];
    assign reg_wr_mask = lane_mask(avs_byteenable);

endmodule

//--- hdl/reset_source_combiner_status.sv
// Operation
// - One unit alone drives master system reset.
// - Any active source asserts master reset.
// - Nine sources accepted, no others.
// - Master reset forces defined registers to defaults.
// - Undefined-value registers survive non-power-on resets.
// - Each reset sets its own status flag.
// - Power-on clears flags, sets bits one, zero.
// - Software may write any status bit anytime.
// - Software-set flags never cause a reset.
// - Trap conflict sets bit fifteen.
// - Illegal opcode, mode, pointer set bit fourteen.
// - Configuration mismatch sets bit nine.
// - External clear pin sets bit seven.
// - Watchdog time-out resets and sets flag.
// - Watchdog clear, power-save, power-on clear flag.
// - Brown-out and power-on set brown-out flag.
// - Unprogrammed watchdog field forces watchdog on.
// - Software brown-out enable honoured only at '01'.
//
// Implementation choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module reset_source_combiner_status (
    input  wire logic                                ref_clk,
    input  wire logic                                resetn,
    input  wire logic                                external_clear_pin_n,
    input  wire reset_cause_pkg::reset_src_t            reset_src,
    input  wire reset_cause_pkg::instr_evt_t            instr_evt,
    input  wire logic [1:0]                          watchdog_config_field,
    input  wire logic [1:0]                          brownout_config_field,
    input  wire logic [reset_cause_pkg::AVS_ADDR_W-1:0] avs_address,
    input  wire logic                                avs_read,
    input  wire logic                                avs_write,
    input  wire logic [reset_cause_pkg::AVS_DATA_W-1:0] avs_writedata,
    input  wire logic [reset_cause_pkg::AVS_BE_W-1:0]   avs_byteenable,
    output logic      [reset_cause_pkg::AVS_DATA_W-1:0] avs_readdata,
    output logic                                     avs_waitrequest,
    output logic                                     master_system_reset,
    output reset_cause_pkg::power_ctl_t                 power_ctl
);
    import reset_cause_pkg::*;

    // ****************************************
    // Declarations.
    // ****************************************
    logic        pin_clear_n_s;
    logic        pin_clear;
    logic        any_source;
    logic        illegal_evt;
    logic        watchdog_clear;
    logic        sleep_evt;
    logic        idle_evt;
    logic [15:0] set_evt;
    logic [15:0] clr_evt;
    logic [15:0] status_r;
    logic [15:0] status_nxt;
    logic [15:0] ctrl_r;
    logic [15:0] ctrl_nxt;
    logic [15:0] reg_value;
    logic        reg_wr_en;
    logic [15:0] reg_wr_data;
    logic [15:0] reg_wr_mask;
    logic        watchdog_on_nxt;
    logic        brownout_sw_nxt;

    // ****************************************
    // External clear pin synchroniser.
    // ****************************************
    sync_two_flop #(
        .WIDTH (1),
        .INIT  (32'h1)
    ) u_pin_sync (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .async_in (external_clear_pin_n),
        .sync_out (pin_clear_n_s)
    );

    assign pin_clear = ~pin_clear_n_s;

    // ****************************************
    // Source combination.
    // ****************************************
    assign illegal_evt = reset_src.illegal_opcode
                       | reset_src.illegal_addr_mode
                       | reset_src.uninit_pointer_reset;

    // Only hardware sources feed this term, never the stored flags.
    assign any_source = pin_clear
                      | reset_src.trap_conflict
                      | illegal_evt
                      | reset_src.config_mismatch
                      | reset_src.reset_instr
                      | reset_src.watchdog_timeout
                      | reset_src.brownout;

    // ****************************************
    // Master system reset.
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            master_system_reset <= 1'b1;
        end else begin
            master_system_reset <= any_source;
        end
    end

    // ****************************************
    // Flag set and clear events.
    // ****************************************
    assign sleep_evt = instr_evt.power_save_instr
                     & ~instr_evt.power_save_idle;
    assign idle_evt  = instr_evt.power_save_instr
                     & instr_evt.power_save_idle;
    assign watchdog_clear = instr_evt.watchdog_clear_instr
                          | instr_evt.power_save_instr;

    always_comb begin
        set_evt = 16'h0;
        set_evt[BIT_TRAP_CONFLICT] = reset_src.trap_conflict;
        set_evt[BIT_ILLEGAL_OP]    = illegal_evt;
        set_evt[BIT_CONFIG_MISM]   = reset_src.config_mismatch;
        set_evt[BIT_PIN_RESET]     = pin_clear;
        set_evt[BIT_SOFT_RESET]    = reset_src.reset_instr;
        set_evt[BIT_WATCHDOG_TO]   = reset_src.watchdog_timeout;
        set_evt[BIT_SLEEP]         = sleep_evt;
        set_evt[BIT_IDLE]          = idle_evt;
        set_evt[BIT_BROWNOUT]      = reset_src.brownout;
    end

    always_comb begin
        clr_evt = 16'h0;
        clr_evt[BIT_WATCHDOG_TO] = watchdog_clear;
    end

    // ****************************************
    // Status flags.
    // ****************************************
    // A hardware set wins over a software write or a clear event.
    always_comb begin
        status_nxt = status_r;
        if (reg_wr_en) begin
            status_nxt = (status_r & ~reg_wr_mask)
                       | (reg_wr_data & reg_wr_mask);
        end
        status_nxt = status_nxt & ~clr_evt;
        status_nxt = (status_nxt | set_evt) & STATUS_MASK;
    end

    // Flags keep their value through every reset except power-on.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            status_r <= POWER_ON_VALUE & STATUS_MASK;
        end else begin
            status_r <= status_nxt;
        end
    end

    // ****************************************
    // Power control bits.
    // ****************************************
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (reg_wr_en) begin
            ctrl_nxt = (ctrl_r & ~reg_wr_mask)
                     | (reg_wr_data & reg_wr_mask);
        end
        ctrl_nxt = ctrl_nxt & CTRL_MASK;
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_r <= POWER_ON_VALUE & CTRL_MASK;
        end else if (master_system_reset) begin
            ctrl_r <= CTRL_DEFAULT;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // ****************************************
    // Register read view.
    // ****************************************
    assign reg_value = status_r | ctrl_r;

    // ****************************************
    // Effective enables towards the power logic.
    // ****************************************
    assign watchdog_on_nxt =
        (watchdog_config_field == WATCHDOG_CFG_ALWAYS)
        | ctrl_r[BIT_SW_WATCHDOG_EN];

    assign brownout_sw_nxt =
        (brownout_config_field == BROWNOUT_CFG_SW)
        & ctrl_r[BIT_SW_BROWNOUT_EN];

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            power_ctl <= '0;
        end else begin
            power_ctl.watchdog_enable    <= watchdog_on_nxt;
            power_ctl.sw_brownout_enable <= brownout_sw_nxt;
            power_ctl.retention_enable   <= ctrl_r[BIT_RETENTION_EN];
            power_ctl.fast_wake_select   <= ctrl_r[BIT_FAST_WAKE];
        end
    end

    // ****************************************
    // Register bus slave.
    // ****************************************
    avmm_reg_slave u_slave (
        .ref_clk         (ref_clk),
        .resetn          (resetn),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_byteenable  (avs_byteenable),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .reg_value       (reg_value),
        .reg_wr_en       (reg_wr_en),
        .reg_wr_data     (reg_wr_data),
        .reg_wr_mask     (reg_wr_mask)
    );

endmodule

//--- dv/reset_combiner_properties.sv
`timescale 1ns/1ps
module reset_combiner_properties (
    input wire logic                        ref_clk,
    input wire logic                        resetn,
    input wire logic                        external_clear_pin_n,
    input wire reset_cause_pkg::reset_src_t reset_src,
    input wire reset_cause_pkg::instr_evt_t instr_evt,
    input wire logic [1:0]                  watchdog_config_field,
    input wire logic [1:0]                  brownout_config_field,
    input wire logic [3:0]                  avs_address,
    input wire logic                        avs_read,
    input wire logic                        avs_write,
    input wire logic [31:0]                 avs_writedata,
    input wire logic [3:0]                  avs_byteenable,
    input wire logic [31:0]                 avs_readdata,
    input wire logic                        avs_waitrequest,
    input wire logic                        master_system_reset,
    input wire reset_cause_pkg::power_ctl_t power_ctl
);
    import reset_cause_pkg::*;

    // ********************
    // Sequences and properties.
    // ********************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_take;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence

    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    sequence s_quiet;
        (reset_src == '0 && external_clear_pin_n)[*4];
    endsequence

    a_any_source: assert property (
        |reset_src |=> master_system_reset)
        else $error("source did not raise master reset");
    a_quiet_idle: assert property (
        s_quiet |=> !master_system_reset)
        else $error("master reset without a source");
    a_pin_reset: assert property (
        $fell(external_clear_pin_n) |-> ##[2:4] master_system_reset)
        else $error("clear pin did not raise master reset");
    a_bus_answer: assert property (
        s_take |=> s_answer)
        else $error("bus answer out of step");
    a_upper_zero: assert property (
        avs_read && !avs_waitrequest |->
            avs_readdata[31:16] == '0 && avs_readdata[11:10] == '0)
        else $error("unimplemented bits read nonzero");
    a_unmapped_zero: assert property (
        avs_read && !avs_waitrequest && avs_address != CAUSE_OFFSET |->
            avs_readdata == '0)
        else $error("unmapped read nonzero");
    a_wdt_forced: assert property (
        (watchdog_config_field == WATCHDOG_CFG_ALWAYS)[*2] |->
            power_ctl.watchdog_enable)
        else $error("watchdog not forced on");
    a_bor_gated: assert property (
        brownout_config_field != BROWNOUT_CFG_SW |=>
            !power_ctl.sw_brownout_enable)
        else $error("brown-out enable not gated");
endmodule

bind reset_source_combiner_status reset_combiner_properties u_props (
    .ref_clk, .resetn, .external_clear_pin_n, .reset_src, .instr_evt,
    .watchdog_config_field, .brownout_config_field, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .master_system_reset, .power_ctl
);

//--- dv/src_model.sv
`timescale 1ns/1ps
module src_model (
    input  wire logic                   ref_clk,
    input  wire logic                   fire,
    input  wire logic [3:0]             sel,
    output reset_cause_pkg::reset_src_t reset_src,
    output logic                        external_clear_pin_n
);
    import reset_cause_pkg::*;

    // ********************
    // Detectors: pulse one source, or hold the clear pin low.
    // ********************
    reset_src_t src_r = '0;
    logic [1:0] pin_cnt_r = 2'h0;

    always @(posedge ref_clk) begin
        src_r <= (fire && sel < 4'h8) ? reset_src_t'(8'h01 << sel) : '0;
        if (fire && sel == 4'h8) begin
            pin_cnt_r <= 2'h3;
        end else if (pin_cnt_r != 2'h0) begin
            pin_cnt_r <= pin_cnt_r - 2'h1;
        end
    end

    assign reset_src = src_r;
    assign external_clear_pin_n = (pin_cnt_r == 2'h0);
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import reset_cause_pkg::*;

    // ********************
    // Signals.
    // ********************
    logic                  ref_clk;
    logic                  resetn;
    logic                  external_clear_pin_n;
    reset_src_t            reset_src;
    instr_evt_t            instr_evt;
    logic [1:0]            watchdog_config_field;
    logic [1:0]            brownout_config_field;
    logic [AVS_ADDR_W-1:0] avs_address;
    logic                  avs_read;
    logic                  avs_write;
    logic [AVS_DATA_W-1:0] avs_writedata;
    logic [AVS_BE_W-1:0]   avs_byteenable;
    logic [AVS_DATA_W-1:0] avs_readdata;
    logic                  avs_waitrequest;
    logic                  master_system_reset;
    power_ctl_t            power_ctl;
    logic                  fire = 1'b0;
    logic [3:0]            sel = 4'h0;
    logic                  saw_rst = 1'b0;
    logic [15:0]           exp_reg;
    logic [15:0]           q;
    instr_evt_t            ev_tab [3] = '{3'b100, 3'b010, 3'b011};
    int                    n_fail = 0;
    int                    comparisons = 0;
    int                    cycles = 0;
    int                    seed = 32'hd5f5;

    reset_source_combiner_status dut (
        .ref_clk, .resetn, .external_clear_pin_n, .reset_src, .instr_evt,
        .watchdog_config_field, .brownout_config_field, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .master_system_reset, .power_ctl
    );
    src_model u_src (.ref_clk, .fire, .sel, .reset_src, .external_clear_pin_n);

    // ********************
    // Clock, watchdog and helpers.
    // ********************
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (master_system_reset === 1'b1) saw_rst = 1'b1;
        if (cycles == 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    function automatic logic [15:0] wr_model(input logic [15:0] old, d,
                                             input logic [1:0] be);
        logic [15:0] m;
        m = {{8{be[1]}}, {8{be[0]}}};
        return ((old & ~m) | (d & m)) & 16'hf3ff;
    endfunction

    function automatic logic [15:0] flag_of(input int i);
        case (i)
            0: return 16'h0002;
            1: return 16'h0010;
            2: return 16'h0040;
            3: return 16'h0200;
            7: return 16'h8000;
            8: return 16'h0080;
            default: return 16'h4000;
        endcase
    endfunction

    function automatic logic [15:0] save_flag(input instr_evt_t e);
        if (!e.power_save_instr) return 16'h0000;
        return e.power_save_idle ? 16'h0004 : 16'h0008;
    endfunction

    function automatic logic [15:0] pc_of(input logic [15:0] r);
        return {12'h0, watchdog_config_field == WATCHDOG_CFG_ALWAYS || r[5],
                brownout_config_field == BROWNOUT_CFG_SW && r[13], r[12], r[8]};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        comparisons++;
        if (got !== want) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic bus(input logic wr_en, input logic [3:0] a,
                       input logic [15:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= wr_en;
        avs_read <= !wr_en;
        avs_writedata <= {16'h0, d};
        avs_byteenable <= be;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 64);
        q = avs_readdata[15:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 64) begin
            n_fail++;
            $display("mismatch at %0t: bus hang", $time);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d,
                      input logic [3:0] be);
        bus(1'b1, a, d, be);
        if (a == CAUSE_OFFSET) exp_reg = wr_model(exp_reg, d, be[1:0]);
    endtask

    task automatic rd(input logic [3:0] a, input logic [15:0] want);
        bus(1'b0, a, 16'h0, 4'hf);
        chk(q, want);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ********************
    // Main sequence.
    // ********************
    initial begin
        resetn = 1'b0;
        instr_evt = '0;
        watchdog_config_field = 2'h3;
        brownout_config_field = 2'h1;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        avs_byteenable = '0;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        exp_reg = 16'h2003;
        rd(CAUSE_OFFSET, exp_reg);
        saw_rst = 1'b0;
        wr(CAUSE_OFFSET, 16'hffff, 4'h3);
        rd(CAUSE_OFFSET, exp_reg);
        chk(pc_of(exp_reg), {12'h0, power_ctl});
        rd(4'h4, 16'h0000);
        wr(4'h4, 16'h0000, 4'h3);
        wr(CAUSE_OFFSET, 16'h0000, 4'h1);
        rd(CAUSE_OFFSET, exp_reg);
        chk({15'h0, saw_rst}, 16'h0000);
        for (int i = 0; i < 9; i++) begin
            wr(CAUSE_OFFSET, 16'h0000, 4'h3);
            saw_rst = 1'b0;
            @(posedge ref_clk);
            fire <= 1'b1;
            sel <= 4'(i);
            @(posedge ref_clk);
            fire <= 1'b0;
            repeat (10) @(posedge ref_clk);
            chk({15'h0, saw_rst}, 16'h0001);
            rd(CAUSE_OFFSET, flag_of(i) | 16'h2000);
        end
        for (int i = 0; i < 3; i++) begin
            wr(CAUSE_OFFSET, 16'h0010, 4'h3);
            @(posedge ref_clk);
            instr_evt <= ev_tab[i];
            @(posedge ref_clk);
            instr_evt <= '0;
            rd(CAUSE_OFFSET, save_flag(ev_tab[i]));
        end
        exp_reg = save_flag(ev_tab[2]);
        saw_rst = 1'b0;
        for (int i = 0; i < 24; i++) begin
            watchdog_config_field <= 2'($random(seed));
            brownout_config_field <= 2'($random(seed));
            wr(CAUSE_OFFSET, 16'($random(seed)), 4'($random(seed)));
            rd(CAUSE_OFFSET, exp_reg);
            chk(pc_of(exp_reg), {12'h0, power_ctl});
        end
        chk({15'h0, saw_rst}, 16'h0000);
        resetn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(CAUSE_OFFSET, 16'h2003);
        wrap_up();
    end
endmodule
